// >>> rtl/terr_adtrig.sv
`include "terr_cfg.svh"
module terr_adtrig (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_flag,
  input  wire logic i_en,
  output logic      o_start
);
  logic flag_d_r;
  // Only the rising edge of the flag starts a conversion
  wire  start_nxt = i_flag & ~flag_d_r & i_en;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      flag_d_r <= 1'b0;
      o_start  <= 1'b0;
    end else begin
      flag_d_r <= i_flag;
      o_start  <= start_nxt;
    end
  end

  adc_cause_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_start |-> ($past(i_en) && $past(i_flag) && !$past(flag_d_r)))
    else $error("start without a fresh flag");
  adc_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_start |=> !o_start) else $error("start longer than one cycle");
endmodule

// >>> rtl/terr_cfg.svh
`ifndef TERR_CFG_SVH
`define TERR_CFG_SVH
// ==========================================
// Sizes
`define TERR_NCH       5
`define TERR_NSRC      23
`define TERR_NSLOT     6
`define TERR_NCC       4
`define TERR_NCC_SHORT 2
`define TERR_AW        4
`define TERR_DW        8
`define TERR_IDW       5
// ==========================================
// Register offsets (word index on the plain port)
`define TERR_OFS_FLAG0 4'h0
`define TERR_OFS_ENA0  4'h1
`define TERR_OFS_STEP  2
`define TERR_OFS_MODE  4'hA
// ==========================================
// Field positions
`define TERR_B_OVF     4
`define TERR_B_UNF     5
`define TERR_B_ADC     7
`define TERR_B_CPWM    0
`define TERR_B_FIRST   0
// ==========================================
// Reset values and channel masks
`define TERR_RST_ENA   8'h00
`define TERR_RST_MODE  1'b0
`define TERR_RST_FLAG  1'b0
`define TERR_SHORT_CHS 5'h06
`define TERR_UNF_CHS   5'h06
`define TERR_CH_CPWM   4
`define TERR_DTC_MASK  23'h7DE66F
`endif

// >>> rtl/terr_flag.sv
`include "terr_cfg.svh"
module terr_flag (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_set,
  input  wire logic i_rd,
  input  wire logic i_wr,
  input  wire logic i_wdat,
  input  wire logic i_auto,
  output logic      o_flag
);
  logic flag_r;
  logic arm_r;
  wire  clr_w    = (i_wr & ~i_wdat & arm_r) | i_auto;
  // An event in the clearing cycle is kept: set wins
  wire  flag_nxt = i_set | (flag_r & ~clr_w);
  // Arming needs a read that saw 1; any write disarms
  wire  arm_nxt  = (i_rd & flag_r) | (arm_r & ~i_wr & flag_r);
  // ==========================================
  // Flag and clear arm
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      flag_r <= `TERR_RST_FLAG;
      arm_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      arm_r  <= arm_nxt;
    end
  end
  assign o_flag = flag_r;

  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_set |=> o_flag) else $error("flag lost a set");
  noarm_keep_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (flag_r && i_wr && !i_wdat && !arm_r && !i_auto) |=> o_flag)
    else $error("flag cleared without a prior read of 1");
endmodule

// >>> rtl/terr_pkg.sv
`include "terr_cfg.svh"
package terr_pkg;
  // Per-channel events from the counter datapath, one-cycle pulses
  typedef struct packed {
    logic [`TERR_NCC-1:0] cc;
    logic                 ovf;
    logic                 unf;
  } terr_evt_t;
  // Plain register port
  typedef struct packed {
    logic [`TERR_AW-1:0] addr;
    logic [`TERR_DW-1:0] wdata;
    logic                we;
    logic                re;
  } terr_bus_t;
  typedef logic [`TERR_NSRC-1:0] terr_src_t;
endpackage

// >>> rtl/terr_router.sv
// What this block does
// - Three source kinds, each with its own flag and enable bit.
// - An event sets its flag; flag and enable raise a request.
// - A request drops when its flag is cleared or its enable bit is cleared.
// - Ranking is fixed inside and across channels; channel 0 ranks first.
// - Sixteen compare/capture sources: 4,2,2,4,4 over channels 0 to 4.
// - Every channel has one overflow source cleared with its flag.
// - Only channels 1 and 2 have an underflow source.
// - Seventeen transfer sources: all compare/capture plus channel 4 overflow.
// - Only each channel's first register may start the DMA unit.
// - First-register flag rising with trigger enable starts a conversion.
// - Reset ranking runs from channel 0 first to channel 4 overflow.
// - Clear by reading 1 then writing 0; transfer ack also clears.
// - Channel 4 underflow sets its overflow flag in complementary mode.
//
// Our own choices: the address map and the address-and-strobe port.
`include "terr_cfg.svh"
module terr_router (
  input  wire logic                           I_CLK,
  input  wire logic                           I_RSTN,
  input  wire terr_pkg::terr_bus_t            I_BUS,
  input  wire terr_pkg::terr_evt_t [`TERR_NCH-1:0] I_EVT,
  input  wire logic [`TERR_NSRC-1:0]          I_DTC_ACK,
  input  wire logic [`TERR_NCH-1:0]           I_DMA_ACK,
  output logic [`TERR_DW-1:0]                 O_RDATA,
  output logic [`TERR_NSRC-1:0]               O_IRQ,
  output logic [`TERR_NSRC-1:0]               O_DTC_REQ,
  output logic [`TERR_NCH-1:0]                O_DMA_REQ,
  output logic [`TERR_NCH-1:0]                O_ADC_START,
  output logic                                O_IRQ_ANY,
  output logic [`TERR_IDW-1:0]                O_IRQ_TOP
);
  import terr_pkg::*;

  // ==========================================
  // Source map helpers
  // Number of compare/capture registers on a channel
  function automatic int cc_cnt(input int ch);
    logic [`TERR_NCH-1:0] m;
    m = `TERR_SHORT_CHS;
    return m[ch] ? `TERR_NCC_SHORT : `TERR_NCC;
  endfunction

  // Does slot s exist on channel ch
  function automatic bit has_slot(input int ch, input int s);
    logic [`TERR_NCH-1:0] u;
    u = `TERR_UNF_CHS;
    if (s < `TERR_NCC) begin
      return s < cc_cnt(ch);
    end
    if (s == `TERR_B_OVF) begin
      return 1'b1;
    end
    return u[ch];
  endfunction

  // Position of a source in the request vector, lowest is highest rank
  function automatic int src_idx(input int ch, input int s);
    int idx;
    idx = 0;
    for (int c = 0; c < ch; c++) begin
      for (int k = 0; k < `TERR_NSLOT; k++) begin
        if (has_slot(c, k)) begin
          idx++;
        end
      end
    end
    for (int k = 0; k < s; k++) begin
      if (has_slot(ch, k)) begin
        idx++;
      end
    end
    return idx;
  endfunction

  // Writable enable bits of a channel
  function automatic logic [`TERR_DW-1:0] ena_mask(input int ch);
    logic [`TERR_DW-1:0] m;
    m = '0;
    for (int k = 0; k < `TERR_NSLOT; k++) begin
      m[k] = has_slot(ch, k);
    end
    m[`TERR_B_ADC] = 1'b1;
    return m;
  endfunction

  function automatic logic [`TERR_AW-1:0] flag_adr(input int ch);
    return `TERR_AW'(ch * `TERR_OFS_STEP) + `TERR_OFS_FLAG0;
  endfunction

  function automatic logic [`TERR_AW-1:0] ena_adr(input int ch);
    return `TERR_AW'(ch * `TERR_OFS_STEP) + `TERR_OFS_ENA0;
  endfunction

  // Fixed ranking: lowest set index wins
  function automatic logic [`TERR_IDW-1:0] prio_top(input terr_src_t v);
    logic [`TERR_IDW-1:0] t;
    t = '0;
    for (int i = `TERR_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        t = `TERR_IDW'(i);
      end
    end
    return t;
  endfunction

  // ==========================================
  // Storage and shared nets
  // Transfer-capable sources as a vector, so one bit can be picked per slot
  localparam terr_src_t DMASK = `TERR_DTC_MASK;
  logic [`TERR_DW-1:0] en_r [`TERR_NCH];
  logic                mode_r;
  terr_src_t           flag_v;
  terr_src_t           en_v;
  terr_src_t           set_v;
  wire logic [`TERR_NSLOT-1:0] fview [`TERR_NCH];
  wire logic [`TERR_DW-1:0]    rd_acc [`TERR_NCH+1];
  wire logic [`TERR_NCH-1:0]   first_flag;

  // Bus strobes, decoded per channel below
  wire logic bus_we = I_BUS.we;
  wire logic bus_re = I_BUS.re;
  wire logic mode_wr = bus_we & (I_BUS.addr == `TERR_OFS_MODE);
  wire logic mode_hit = I_BUS.addr == `TERR_OFS_MODE;

  // ==========================================
  // Per-channel registers and flag cells
  assign rd_acc[0] = mode_hit ? {{(`TERR_DW-1){1'b0}}, mode_r} : '0;

  for (genvar ch = 0; ch < `TERR_NCH; ch++) begin : g_ch
    localparam logic [`TERR_DW-1:0] EMASK = ena_mask(ch);
    localparam int                  FIRST = src_idx(ch, `TERR_B_FIRST);
    wire logic f_hit = I_BUS.addr == flag_adr(ch);
    wire logic e_hit = I_BUS.addr == ena_adr(ch);
    wire logic f_rd  = bus_re & f_hit;
    wire logic f_wr  = bus_we & f_hit;
    wire logic e_wr  = bus_we & e_hit;
    // Unused enable bits never store, so they read as zero
    wire logic [`TERR_DW-1:0] e_nxt = I_BUS.wdata & EMASK;

    // Read data of this channel's two registers
    assign rd_acc[ch+1] = rd_acc[ch]
                        | (f_hit ? {{(`TERR_DW-`TERR_NSLOT){1'b0}}, fview[ch]} : '0)
                        | (e_hit ? en_r[ch] : '0);

    // Enable register of the channel
    always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
        en_r[ch] <= `TERR_RST_ENA;
      end else if (e_wr) begin
        en_r[ch] <= e_nxt;
      end
    end

    for (genvar s = 0; s < `TERR_NSLOT; s++) begin : g_slot
      if (has_slot(ch, s)) begin : g_on
        localparam int IX = src_idx(ch, s);
        localparam bit DTC_OK = DMASK[IX];
        wire logic ev;
        wire logic ack;
        if (s < `TERR_NCC) begin : g_cc
          assign ev = I_EVT[ch].cc[s];
        end else if (s == `TERR_B_OVF && ch == `TERR_CH_CPWM) begin : g_ov4
          // Complementary mode folds the underflow into this flag
          assign ev = I_EVT[ch].ovf | (mode_r & I_EVT[ch].unf);
        end else if (s == `TERR_B_OVF) begin : g_ov
          assign ev = I_EVT[ch].ovf;
        end else begin : g_un
          assign ev = I_EVT[ch].unf;
        end
        // Only transfer-capable sources listen to an ack
        if (s == `TERR_B_FIRST) begin : g_ack1
          assign ack = I_DMA_ACK[ch] | (DTC_OK & I_DTC_ACK[IX]);
        end else begin : g_ackn
          assign ack = DTC_OK & I_DTC_ACK[IX];
        end
        terr_flag u_flag (
          .i_clk  (I_CLK),
          .i_rstn (I_RSTN),
          .i_set  (ev),
          .i_rd   (f_rd),
          .i_wr   (f_wr),
          .i_wdat (I_BUS.wdata[s]),
          .i_auto (ack),
          .o_flag (flag_v[IX])
        );
        assign set_v[IX]     = ev;
        assign en_v[IX]      = en_r[ch][s];
        assign fview[ch][s]  = flag_v[IX];
      end else begin : g_off
        assign fview[ch][s] = 1'b0;
      end
    end

    assign first_flag[ch] = flag_v[FIRST];

    // A/D start from the first register only
    terr_adtrig u_adc (
      .i_clk   (I_CLK),
      .i_rstn  (I_RSTN),
      .i_flag  (first_flag[ch]),
      .i_en    (en_r[ch][`TERR_B_ADC]),
      .o_start (O_ADC_START[ch])
    );
  end

  // ==========================================
  // Mode register
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      mode_r <= `TERR_RST_MODE;
    end else if (mode_wr) begin
      mode_r <= I_BUS.wdata[`TERR_B_CPWM];
    end
  end

  // ==========================================
  // Request formation
  // Level requests; an enable drop also hides it, but the flag is what clears it
  wire terr_src_t irq_nxt = flag_v & en_v;
  wire terr_src_t dtc_nxt = irq_nxt & `TERR_DTC_MASK;
  wire logic [`TERR_NCH-1:0] dma_nxt;
  for (genvar ch = 0; ch < `TERR_NCH; ch++) begin : g_dma
    assign dma_nxt[ch] = irq_nxt[src_idx(ch, `TERR_B_FIRST)];
  end
  wire logic [`TERR_IDW-1:0] top_nxt = prio_top(irq_nxt);
  wire logic any_nxt = |irq_nxt;
  wire logic [`TERR_DW-1:0] rd_nxt = bus_re ? rd_acc[`TERR_NCH] : '0;

  // All outputs leave from flops so the partners see clean levels
  always_ff @(posedge I_CLK) begin
    if (!I_RSTN) begin
      O_IRQ     <= '0;
      O_DTC_REQ <= '0;
      O_DMA_REQ <= '0;
      O_IRQ_ANY <= 1'b0;
      O_IRQ_TOP <= '0;
      O_RDATA   <= '0;
    end else begin
      O_IRQ     <= irq_nxt;
      O_DTC_REQ <= dtc_nxt;
      O_DMA_REQ <= dma_nxt;
      O_IRQ_ANY <= any_nxt;
      O_IRQ_TOP <= top_nxt;
      O_RDATA   <= rd_nxt;
    end
  end

  // ==========================================
  // Checks
  wire logic any_clr = bus_we | (|I_DTC_ACK) | (|I_DMA_ACK);
  wire logic [`TERR_AW-1:0] ch0_flag_adr = flag_adr(0);

  flag_set_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (|set_v) |=> ((flag_v & $past(set_v)) == $past(set_v)))
    else $error("event did not set its flag");

  irq_follow_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    ##1 (O_IRQ == $past(flag_v & en_v)))
    else $error("request is not flag and enable");

  flag_hold_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    ((~flag_v & $past(flag_v)) != '0) |-> $past(any_clr))
    else $error("flag fell without a clear");

  cpwm_ovf_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (mode_r && I_EVT[`TERR_CH_CPWM].unf)
    |=> ##1 (O_IRQ[`TERR_NSRC-1] || !$past(en_v[`TERR_NSRC-1])))
    else $error("underflow missed the overflow flag");

  dtc_only_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (O_DTC_REQ & ~`TERR_DTC_MASK) == '0 && O_DTC_REQ == (O_IRQ & `TERR_DTC_MASK))
    else $error("transfer request from a non-capable source");

  dma_first_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    ##1 (O_DMA_REQ == $past(dma_nxt)) && (O_DMA_REQ[0] == O_IRQ[0]))
    else $error("dma request not from a first register");

  prio_top_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    O_IRQ_ANY |-> (O_IRQ[O_IRQ_TOP]
      && ((O_IRQ & ((`TERR_NSRC'(1) << O_IRQ_TOP) - `TERR_NSRC'(1))) == '0)))
    else $error("wrong top ranked request");

  unf_none_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (fview[0][`TERR_B_UNF] == 1'b0) && (fview[3][`TERR_B_UNF] == 1'b0)
    && (en_r[4][`TERR_B_UNF] == 1'b0))
    else $error("underflow bit on a channel without one");

  flag_read_a: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
    (bus_re && I_BUS.addr == ch0_flag_adr)
    |=> (O_RDATA[`TERR_NSLOT-1:0] == $past(fview[0])))
    else $error("flag read returned wrong data");
endmodule

// >>> tb/terr_far_side.sv
// ==========================================
// Transfer units and converter on the far side
module terr_far_side (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [22:0] i_dtc_req,
  input  wire logic [4:0]  i_dma_req,
  input  wire logic [4:0]  i_adc_start,
  input  wire logic        i_ack_en,
  input  wire logic        i_adc_sel,
  output logic [22:0]      o_dtc_ack,
  output logic [4:0]       o_dma_ack,
  output logic [7:0]       o_conv_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [22:0] dtc_r = '0;
  logic [4:0]  dma_r = '0;
  logic [7:0]  cnt_r = '0;
  // Ack one cycle after a request; a live request may be acked again
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      dtc_r <= '0;
      dma_r <= '0;
      cnt_r <= '0;
    end else begin
      dtc_r <= i_ack_en ? (i_dtc_req & ~dtc_r) : '0;
      dma_r <= i_ack_en ? (i_dma_req & ~dma_r) : '0;
      if (i_adc_sel && (i_adc_start != 5'h00)) cnt_r <= cnt_r + 8'h01;
    end
  end
  // Outputs follow the registers
  assign o_dtc_ack  = dtc_r;
  assign o_dma_ack  = dma_r;
  assign o_conv_cnt = cnt_r;
endmodule

// >>> tb/terr_router_tb.sv
`include "terr_cfg.svh"
module terr_router_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import terr_pkg::*;
  // ==========================================
  // Signals
  logic            clk;
  logic            rstn = 1'b0;
  terr_bus_t       bus = '0;
  terr_evt_t [4:0] ev = '0;
  logic [22:0]     dtc_ack;
  logic [4:0]      dma_ack;
  logic [7:0]      rdata;
  logic [22:0]     irq;
  logic [22:0]     dtc_req;
  logic [4:0]      dma_req;
  logic [4:0]      adc;
  logic            any;
  logic [4:0]      top;
  logic            ack_en = 1'b0;
  logic            adc_sel = 1'b1;
  logic [7:0]      conv;
  logic [7:0]      d;
  int              bad_count = 0;
  int              checked = 0;
  // Channel and bit of each request index
  localparam int SCH [23] = '{0,0,0,0,0,1,1,1,1,2,2,2,2,3,3,3,3,3,4,4,4,4,4};
  localparam int SB [23]  = '{0,1,2,3,4,0,1,4,5,0,1,4,5,0,1,2,3,4,0,1,2,3,4};
  // ==========================================
  // Instances
  terr_router dut (.I_CLK(clk), .I_RSTN(rstn), .I_BUS(bus), .I_EVT(ev),
    .I_DTC_ACK(dtc_ack), .I_DMA_ACK(dma_ack), .O_RDATA(rdata), .O_IRQ(irq),
    .O_DTC_REQ(dtc_req), .O_DMA_REQ(dma_req), .O_ADC_START(adc),
    .O_IRQ_ANY(any), .O_IRQ_TOP(top));
  terr_far_side far (.i_clk(clk), .i_rstn(rstn), .i_dtc_req(dtc_req),
    .i_dma_req(dma_req), .i_adc_start(adc), .i_ack_en(ack_en),
    .i_adc_sel(adc_sel), .o_dtc_ack(dtc_ack), .o_dma_ack(dma_ack),
    .o_conv_cnt(conv));
  // Clock at 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ==========================================
  // Helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Sample just after an edge so its updates have landed
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask
  // Pulse one channel's events; returns where requests show
  task automatic evt(input int ch, input logic [5:0] f);
    @(posedge clk);
    ev[ch] <= f;
    @(posedge clk);
    ev <= '0;
    tick();
  endtask
  function automatic logic [5:0] fld(input int b);
    return (b < 4) ? 6'(1 << (b + 2)) : ((b == 4) ? 6'h02 : 6'h01);
  endfunction
  // ==========================================
  // Scenarios
  task automatic t_gate;
    evt(0, fld(0));
    chk("irq off", 32'(irq), 32'h0);
    wr(4'h1, 8'h01);
    tick();
    chk("irq on", 32'(irq), 32'h1);
    wr(4'h0, 8'h00);
    tick();
    chk("no read", 32'(irq), 32'h1);
    rd(4'h0, d);
    chk("flag", 32'(d), 32'h1);
    wr(4'h0, 8'h00);
    tick();
    chk("cleared", 32'(irq), 32'h0);
  endtask
  // Every source alone: index, transfer and DMA capability
  task automatic t_all;
    for (int i = 0; i < 23; i++) begin
      wr(4'(2 * SCH[i] + 1), 8'h3F);
      rd(4'(2 * SCH[i] + 1), d);
      chk("ena", 32'(d), (SCH[i] == 1 || SCH[i] == 2) ? 32'h33 : 32'h1F);
      evt(SCH[i], fld(SB[i]));
      chk("irq", 32'(irq), 32'(1) << i);
      chk("dtc", 32'(dtc_req), (SB[i] < 4 || i == 22) ? 32'(1) << i : 32'h0);
      chk("dma", 32'(dma_req), (SB[i] == 0) ? 32'(1) << SCH[i] : 32'h0);
      chk("top", 32'(top), 32'(i));
      chk("any", 32'(any), 32'h1);
      chk("adc", 32'(adc), 32'h0);
      rd(4'(2 * SCH[i]), d);
      chk("flag", 32'(d), 32'(1) << SB[i]);
      wr(4'(2 * SCH[i]), 8'h00);
      tick();
      chk("drop", 32'(irq), 32'h0);
    end
  endtask
  task automatic t_odd;
    evt(1, 6'h10);
    evt(0, 6'h01);
    chk("absent", 32'(irq), 32'h0);
    evt(4, 6'h01);
    chk("unf plain", 32'(irq), 32'h0);
    wr(4'hA, 8'h01);
    evt(4, 6'h01);
    chk("unf cpwm", 32'(irq), 32'h400000);
    rd(4'h8, d);
    chk("ovf flag", 32'(d), 32'h10);
    wr(4'h8, 8'h00);
    wr(4'hA, 8'h00);
  endtask
  // Transfer acks clear the flag; trigger enable gates the converter
  task automatic t_auto;
    ack_en <= 1'b1;
    wr(4'h1, 8'h81);
    evt(0, fld(0));
    chk("adc", 32'(adc), 32'h1);
    chk("dma", 32'(dma_req), 32'h1);
    tick();
    chk("adc pulse", 32'(adc), 32'h0);
    repeat (3) tick();
    chk("auto clr", 32'(irq), 32'h0);
    chk("conv", 32'(conv), 32'h1);
    wr(4'h1, 8'h01);
    evt(0, fld(0));
    chk("adc off", 32'(adc), 32'h0);
    repeat (4) tick();
    // Converter not pointed at this timer: the start is sent but ignored
    adc_sel <= 1'b0;
    wr(4'h1, 8'h81);
    evt(0, fld(0));
    chk("adc sel", 32'(adc), 32'h1);
    repeat (4) tick();
    chk("conv held", 32'(conv), 32'h1);
    ack_en <= 1'b0;
  endtask
  // Channel 0 second register against channel 4 first register
  task automatic t_prio;
    wr(4'h1, 8'h03);
    @(posedge clk);
    ev[4] <= fld(0);
    ev[0] <= fld(1);
    @(posedge clk);
    ev <= '0;
    tick();
    chk("prio irq", 32'(irq), 32'h40002);
    chk("prio top", 32'(top), 32'h1);
  endtask
  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk("rst irq", 32'(irq), 32'h0);
    chk("rst adc", 32'(adc), 32'h0);
    t_gate();
    t_all();
    t_odd();
    t_auto();
    t_prio();
    summarize();
  end
  // Watchdog far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule
